// >>> inc/sync_latch_regs.vh
// register map and timing constants of the sync pulse and capture unit
// assumes byte-wide register ports addressed by the printed byte offsets
`ifndef SYNC_LATCH_REGS_VH
`define SYNC_LATCH_REGS_VH

`define ADDR_W              12
`define ACT_STATUS_ADDR     12'h984
`define SYNC_A_STAT_ADDR    12'h98E
`define SYNC_B_STAT_ADDR    12'h98F
`define START_TIME_ADDR     12'h990
`define NEXT_B_TIME_ADDR    12'h998
`define CYCLE_A_ADDR        12'h9A0
`define CYCLE_B_ADDR        12'h9A4
`define CAP_A_CTRL_ADDR     12'h9A8
`define CAP_B_CTRL_ADDR     12'h9A9
`define CAP_A_STAT_ADDR     12'h9AE
`define CAP_A_RISE_ADDR     12'h9B0
`define CAP_A_FALL_ADDR     12'h9B8
`define CAP_B_RISE_ADDR     12'h9C0
`define CAP_B_FALL_ADDR     12'h9C8

`define ACT_PEND_A_BIT      0
`define ACT_PEND_B_BIT      1
`define ACT_PLAUS_BIT       2
`define ACK_STATE_BIT       0
`define CTRL_RISE_BIT       0
`define CTRL_FALL_BIT       1
`define CAP_RISE_FLAG_BIT   0
`define CAP_FALL_FLAG_BIT   1
`define CAP_PIN_BIT         2

`define REG8_RESET          8'h00
`define REG32_RESET         32'h00000000
`define REG64_RESET         64'h0000000000000000
`define CTRL_RESET          2'h0

`define CLK_PERIOD_NS       25
`define PULSE_UNIT_NS       10
`define NEAR_FUTURE_NS      64'h0000000080000000

`endif

// >>> logic/sync_out_stage.v
// one sync output: timed pulse or level held until acknowledged by a read
// assumes fire and ack strobes are single-cycle pulses on the same clock
`timescale 1ns/1ps
`include "sync_latch_regs.vh"
module sync_out_stage (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_fire,
    input  wire        i_ack_clr,
    input  wire [15:0] i_pulse_len,
    output wire        o_level,
    output wire        o_ack_state
);
    localparam [23:0] STEP_NS = `CLK_PERIOD_NS;
    localparam [23:0] UNIT_NS = `PULSE_UNIT_NS;

    reg  [23:0] rem_ns_q;
    reg  [23:0] rem_ns_d;
    reg         ack_lvl_q;
    reg         ack_lvl_d;
    wire        ack_mode = (i_pulse_len == 16'h0000);

    always @* begin
        rem_ns_d  = (rem_ns_q > STEP_NS) ? rem_ns_q - STEP_NS : 24'h000000;
        ack_lvl_d = ack_lvl_q;
        if (i_ack_clr)
            ack_lvl_d = 1'b0;
        if (ack_mode && i_fire)
            ack_lvl_d = 1'b1;
        if (!ack_mode)
            ack_lvl_d = 1'b0;
        if (!ack_mode && i_fire)
            rem_ns_d = {8'h00, i_pulse_len} * UNIT_NS;
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rem_ns_q  <= 24'h000000;
            ack_lvl_q <= 1'b0;
        end else begin
            rem_ns_q  <= rem_ns_d;
            ack_lvl_q <= ack_lvl_d;
        end
    end

    assign o_level     = ack_mode ? ack_lvl_q : (rem_ns_q != 24'h000000);
    assign o_ack_state = ack_lvl_q;
endmodule // sync_out_stage

// >>> logic/edge_capture.v
// one capture input: synchroniser, edge detect, timestamp and event flags
// assumes the pin is asynchronous and system time is on this clock
`timescale 1ns/1ps
`include "sync_latch_regs.vh"
module edge_capture (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_pin,
    input  wire [63:0] i_sys_time,
    input  wire [1:0]  i_mode,
    input  wire        i_rise_clr,
    input  wire        i_fall_clr,
    output reg  [63:0] o_rise_time,
    output reg  [63:0] o_fall_time,
    output reg         o_rise_flag,
    output reg         o_fall_flag,
    output wire        o_pin_state
);
    reg  meta_q;
    reg  sync_q;
    reg  last_q;
    wire rise = sync_q & ~last_q;
    wire fall = ~sync_q & last_q;
    wire r_single = i_mode[`CTRL_RISE_BIT];
    wire f_single = i_mode[`CTRL_FALL_BIT];
    // a clear in the same cycle reopens capture, so the new edge is kept
    wire r_take = rise & (~r_single | ~o_rise_flag | i_rise_clr);
    wire f_take = fall & (~f_single | ~o_fall_flag | i_fall_clr);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q      <= 1'b0;
            sync_q      <= 1'b0;
            last_q      <= 1'b0;
            o_rise_time <= `REG64_RESET;
            o_fall_time <= `REG64_RESET;
            o_rise_flag <= 1'b0;
            o_fall_flag <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
            if (r_take)
                o_rise_time <= i_sys_time;
            if (f_take)
                o_fall_time <= i_sys_time;
            if (!r_single)
                o_rise_flag <= 1'b0;
            else if (r_take)
                o_rise_flag <= 1'b1;
            else if (i_rise_clr)
                o_rise_flag <= 1'b0;
            if (!f_single)
                o_fall_flag <= 1'b0;
            else if (f_take)
                o_fall_flag <= 1'b1;
            else if (i_fall_clr)
                o_fall_flag <= 1'b0;
        end
    end

    assign o_pin_state = sync_q;
endmodule // edge_capture

// >>> logic/sync_latch_unit.v
// sync pulse generator and capture unit with network and host register ports
// assumes system time, frame end and activation controls come from this clock
//
// Notes on behaviour
// - at activation, status bit 2 records whether start time lay outside near future
// - status bit 1 is high while first pulse of output b is pending
// - status bit 0 is high while first pulse of output a is pending
// - ack mode: output a holds until host reads its status, read clears it
// - ack mode: output b holds until host reads its status, read clears it
// - start time write sets cyclic start; read returns next output a time
// - start time writes accepted only while sync ownership is network side
// - auto-activation with only low word written in a frame extends upper word
// - read-only register gives time of next output b pulse
// - output a pulses are spaced by the 32-bit cycle time in ns
// - cycle time zero gives a single output a pulse
// - output b follows each output a pulse by the second cycle time
// - cycle time writes only from the side owning the sync unit
// - capture a control: bit 1 falling, bit 0 rising; 1 means single event
// - capture b control uses the same per-edge mode bits
// - capture a control writes only from its owning side
// - capture b control writes only from its owning side
// - capture a status bit 1 flags a falling edge in single mode only
// - reading the falling timestamp clears the falling flag
// - capture a status bit 0 flags a rising edge in single mode only
// - reading the rising timestamp clears the rising flag
// - pulse length zero selects acknowledge mode
// - ownership bit 0 means network side, 1 means host port
// - system time captured on each accepted rising edge of capture a
`timescale 1ns/1ps
`include "sync_latch_regs.vh"
module sync_latch_unit (
    input  wire        I_SYS_CLK,
    input  wire        I_RST_N,
    input  wire [63:0] I_SYS_TIME,
    input  wire        I_FRAME_END,
    input  wire        I_SYNC_OWNER_HOST,
    input  wire        I_CAPA_OWNER_HOST,
    input  wire        I_CAPB_OWNER_HOST,
    input  wire        I_UNIT_ACTIVATE,
    input  wire        I_GEN_A_EN,
    input  wire        I_GEN_B_EN,
    input  wire        I_AUTO_ACTIVATE,
    input  wire        I_PLAUS_CHECK_EN,
    input  wire [15:0] I_PULSE_LEN,
    input  wire [11:0] I_NM_ADDR,
    input  wire        I_NM_WR,
    input  wire        I_NM_RD,
    input  wire [7:0]  I_NM_WDATA,
    output reg  [7:0]  O_NM_RDATA,
    input  wire [11:0] I_HP_ADDR,
    input  wire        I_HP_WR,
    input  wire        I_HP_RD,
    input  wire [7:0]  I_HP_WDATA,
    output reg  [7:0]  O_HP_RDATA,
    input  wire        I_CAPTURE_INPUT_A,
    input  wire        I_CAPTURE_INPUT_B,
    output wire        O_SYNC_PULSE_OUT_A,
    output wire        O_SYNC_PULSE_OUT_B
);
    reg  [63:0] start_q;
    reg  [63:0] next_a_q;
    reg  [63:0] next_b_q;
    reg  [31:0] cycle_a_q;
    reg  [31:0] cycle_b_q;
    reg  [1:0]  cap_a_mode_q;
    reg  [1:0]  cap_b_mode_q;
    reg         run_q;
    reg         armed_b_q;
    reg         pend_a_q;
    reg         pend_b_q;
    reg         plaus_q;
    reg         lo_wr_q;
    reg         hi_wr_q;
    reg         act_last_q;

    wire [63:0] a_rise_t;
    wire [63:0] a_fall_t;
    wire [63:0] b_rise_t;
    wire [63:0] b_fall_t;
    wire        a_rise_f;
    wire        a_fall_f;
    wire        a_pin;
    wire        ack_a;
    wire        ack_b;

    // byte of a 64-bit value, index counted from the lowest address
    function [7:0] byte_of;
        input [63:0] v;
        input [2:0]  k;
        begin
            byte_of = v[{k, 3'b000} +: 8];
        end
    endfunction

    // true when addr lies in the n-byte window starting at base
    function in_win;
        input [11:0] addr;
        input [11:0] base;
        input [3:0]  n;
        begin
            in_win = (addr >= base) && (addr < base + {8'h00, n});
        end
    endfunction

    // signed difference not negative: time t has been reached
    function reached;
        input [63:0] now;
        input [63:0] t;
        reg   [63:0] diff;
        begin
            diff    = now - t;
            reached = ~diff[63];
        end
    endfunction

    // read value of one byte address, reserved bits zero
    function [7:0] read_map;
        input [11:0] a;
        reg   [2:0]  k;
        begin
            k        = a[2:0];
            read_map = `REG8_RESET;
            if (a == `ACT_STATUS_ADDR)
                read_map = {5'h00, plaus_q, pend_b_q, pend_a_q};
            else if (a == `SYNC_A_STAT_ADDR)
                read_map = {7'h00, ack_a};
            else if (a == `SYNC_B_STAT_ADDR)
                read_map = {7'h00, ack_b};
            else if (in_win(a, `START_TIME_ADDR, 4'h8))
                read_map = byte_of(next_a_q, k);
            else if (in_win(a, `NEXT_B_TIME_ADDR, 4'h8))
                read_map = byte_of(next_b_q, k);
            else if (in_win(a, `CYCLE_A_ADDR, 4'h4))
                read_map = byte_of({32'h00000000, cycle_a_q}, k);
            else if (in_win(a, `CYCLE_B_ADDR, 4'h4))
                read_map = byte_of({32'h00000000, cycle_b_q}, {1'b0, k[1:0]});
            else if (a == `CAP_A_CTRL_ADDR)
                read_map = {6'h00, cap_a_mode_q};
            else if (a == `CAP_B_CTRL_ADDR)
                read_map = {6'h00, cap_b_mode_q};
            else if (a == `CAP_A_STAT_ADDR)
                read_map = {5'h00, a_pin, a_fall_f, a_rise_f};
            else if (in_win(a, `CAP_A_RISE_ADDR, 4'h8))
                read_map = byte_of(a_rise_t, k);
            else if (in_win(a, `CAP_A_FALL_ADDR, 4'h8))
                read_map = byte_of(a_fall_t, k);
            else if (in_win(a, `CAP_B_RISE_ADDR, 4'h8))
                read_map = byte_of(b_rise_t, k);
            else if (in_win(a, `CAP_B_FALL_ADDR, 4'h8))
                read_map = byte_of(b_fall_t, k);
        end
    endfunction

    // the owning side's write strobe, address and data
    wire        s_wr   = I_SYNC_OWNER_HOST ? I_HP_WR : I_NM_WR;
    wire [11:0] s_addr = I_SYNC_OWNER_HOST ? I_HP_ADDR : I_NM_ADDR;
    wire [7:0]  s_data = I_SYNC_OWNER_HOST ? I_HP_WDATA : I_NM_WDATA;
    wire        ca_wr  = I_CAPA_OWNER_HOST ? I_HP_WR : I_NM_WR;
    wire [11:0] ca_adr = I_CAPA_OWNER_HOST ? I_HP_ADDR : I_NM_ADDR;
    wire [7:0]  ca_dat = I_CAPA_OWNER_HOST ? I_HP_WDATA : I_NM_WDATA;
    wire        ca_rd  = I_CAPA_OWNER_HOST ? I_HP_RD : I_NM_RD;
    wire [11:0] ca_radr = I_CAPA_OWNER_HOST ? I_HP_ADDR : I_NM_ADDR;
    wire        cb_wr  = I_CAPB_OWNER_HOST ? I_HP_WR : I_NM_WR;
    wire [11:0] cb_adr = I_CAPB_OWNER_HOST ? I_HP_ADDR : I_NM_ADDR;
    wire [7:0]  cb_dat = I_CAPB_OWNER_HOST ? I_HP_WDATA : I_NM_WDATA;

    wire st_wr = I_NM_WR && !I_SYNC_OWNER_HOST
                 && in_win(I_NM_ADDR, `START_TIME_ADDR, 4'h8);
    wire [2:0] st_k = I_NM_ADDR[2:0];

    // activation: rising edge of the activate control or auto-activation
    wire auto_ev = I_AUTO_ACTIVATE && I_FRAME_END && (lo_wr_q || hi_wr_q);
    wire act_ev  = (I_UNIT_ACTIVATE && !act_last_q) || auto_ev;
    wire deact   = !I_UNIT_ACTIVATE && act_last_q;

    // upper word carried over from system time, wrapping forward if needed
    wire [31:0] ext_hi = I_SYS_TIME[63:32]
                         + {31'h00000000, (start_q[31:0] < I_SYS_TIME[31:0])};
    wire        do_ext = auto_ev && lo_wr_q && !hi_wr_q;
    wire [63:0] start_eff = do_ext ? {ext_hi, start_q[31:0]} : start_q;
    wire [63:0] ahead = start_eff - I_SYS_TIME;
    wire        out_near = (ahead >= `NEAR_FUTURE_NS);

    wire fire_a = run_q && I_GEN_A_EN && reached(I_SYS_TIME, next_a_q);
    wire fire_b = armed_b_q && I_GEN_B_EN && reached(I_SYS_TIME, next_b_q);

    integer i;

    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            start_q      <= `REG64_RESET;
            cycle_a_q    <= `REG32_RESET;
            cycle_b_q    <= `REG32_RESET;
            cap_a_mode_q <= `CTRL_RESET;
            cap_b_mode_q <= `CTRL_RESET;
            lo_wr_q      <= 1'b0;
            hi_wr_q      <= 1'b0;
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                if (st_wr && st_k == i[2:0])
                    start_q[i*8 +: 8] <= I_NM_WDATA;
            end
            if (do_ext)
                start_q[63:32] <= ext_hi;
            if (I_FRAME_END) begin
                lo_wr_q <= 1'b0;
                hi_wr_q <= 1'b0;
            end else if (st_wr) begin
                lo_wr_q <= lo_wr_q | ~st_k[2];
                hi_wr_q <= hi_wr_q | st_k[2];
            end
            for (i = 0; i < 4; i = i + 1) begin
                if (s_wr && s_addr == `CYCLE_A_ADDR + i[11:0])
                    cycle_a_q[i*8 +: 8] <= s_data;
                if (s_wr && s_addr == `CYCLE_B_ADDR + i[11:0])
                    cycle_b_q[i*8 +: 8] <= s_data;
            end
            if (ca_wr && ca_adr == `CAP_A_CTRL_ADDR)
                cap_a_mode_q <= ca_dat[1:0];
            if (cb_wr && cb_adr == `CAP_B_CTRL_ADDR)
                cap_b_mode_q <= cb_dat[1:0];
        end
    end

    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            next_a_q   <= `REG64_RESET;
            next_b_q   <= `REG64_RESET;
            run_q      <= 1'b0;
            armed_b_q  <= 1'b0;
            pend_a_q   <= 1'b0;
            pend_b_q   <= 1'b0;
            plaus_q    <= 1'b0;
            act_last_q <= 1'b0;
        end else begin
            act_last_q <= I_UNIT_ACTIVATE;
            if (act_ev) begin
                run_q     <= 1'b1;
                armed_b_q <= 1'b0;
                pend_a_q  <= I_GEN_A_EN;
                pend_b_q  <= I_GEN_B_EN;
                plaus_q   <= out_near;
                if (I_PLAUS_CHECK_EN && out_near)
                    next_a_q <= I_SYS_TIME;
                else
                    next_a_q <= start_eff;
            end else if (deact) begin
                run_q     <= 1'b0;
                armed_b_q <= 1'b0;
                pend_a_q  <= 1'b0;
                pend_b_q  <= 1'b0;
            end else begin
                if (fire_a) begin
                    pend_a_q  <= 1'b0;
                    armed_b_q <= 1'b1;
                    next_b_q  <= next_a_q + {32'h00000000, cycle_b_q};
                    if (cycle_a_q == `REG32_RESET)
                        run_q <= 1'b0;
                    else
                        next_a_q <= next_a_q + {32'h00000000, cycle_a_q};
                end
                if (fire_b && !fire_a) begin
                    armed_b_q <= 1'b0;
                    pend_b_q  <= 1'b0;
                end else if (fire_b) begin
                    pend_b_q  <= 1'b0;
                end
            end
        end
    end

    // register read data, one cycle after the read strobe
    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_NM_RDATA <= `REG8_RESET;
            O_HP_RDATA <= `REG8_RESET;
        end else begin
            O_NM_RDATA <= I_NM_RD ? read_map(I_NM_ADDR) : `REG8_RESET;
            O_HP_RDATA <= I_HP_RD ? read_map(I_HP_ADDR) : `REG8_RESET;
        end
    end

    wire ack_a_clr = I_HP_RD && I_HP_ADDR == `SYNC_A_STAT_ADDR;
    wire ack_b_clr = I_HP_RD && I_HP_ADDR == `SYNC_B_STAT_ADDR;
    wire a_rise_clr = ca_rd && ca_radr == `CAP_A_RISE_ADDR;
    wire a_fall_clr = ca_rd && ca_radr == `CAP_A_FALL_ADDR;

    sync_out_stage u_out_a (
        .i_clk       (I_SYS_CLK),
        .i_rst_n     (I_RST_N),
        .i_fire      (fire_a),
        .i_ack_clr   (ack_a_clr),
        .i_pulse_len (I_PULSE_LEN),
        .o_level     (O_SYNC_PULSE_OUT_A),
        .o_ack_state (ack_a)
    );

    sync_out_stage u_out_b (
        .i_clk       (I_SYS_CLK),
        .i_rst_n     (I_RST_N),
        .i_fire      (fire_b),
        .i_ack_clr   (ack_b_clr),
        .i_pulse_len (I_PULSE_LEN),
        .o_level     (O_SYNC_PULSE_OUT_B),
        .o_ack_state (ack_b)
    );

    edge_capture u_cap_a (
        .i_clk       (I_SYS_CLK),
        .i_rst_n     (I_RST_N),
        .i_pin       (I_CAPTURE_INPUT_A),
        .i_sys_time  (I_SYS_TIME),
        .i_mode      (cap_a_mode_q),
        .i_rise_clr  (a_rise_clr),
        .i_fall_clr  (a_fall_clr),
        .o_rise_time (a_rise_t),
        .o_fall_time (a_fall_t),
        .o_rise_flag (a_rise_f),
        .o_fall_flag (a_fall_f),
        .o_pin_state (a_pin)
    );

    edge_capture u_cap_b (
        .i_clk       (I_SYS_CLK),
        .i_rst_n     (I_RST_N),
        .i_pin       (I_CAPTURE_INPUT_B),
        .i_sys_time  (I_SYS_TIME),
        .i_mode      (cap_b_mode_q),
        .i_rise_clr  (1'b0),
        .i_fall_clr  (1'b0),
        .o_rise_time (b_rise_t),
        .o_fall_time (b_fall_t),
        .o_rise_flag (),
        .o_fall_flag (),
        .o_pin_state ()
    );
endmodule // sync_latch_unit

// >>> tb/sync_latch_unit_props.sv
// port assertions of the sync pulse and capture unit
// assumes the register header is on the include path; bound below
`timescale 1ns/1ps
`include "sync_latch_regs.vh"
module sync_latch_unit_props (
    input wire        I_SYS_CLK,
    input wire        I_RST_N,
    input wire        I_UNIT_ACTIVATE,
    input wire [15:0] I_PULSE_LEN,
    input wire [11:0] I_NM_ADDR,
    input wire        I_NM_RD,
    input wire [7:0]  O_NM_RDATA,
    input wire [11:0] I_HP_ADDR,
    input wire        I_HP_RD,
    input wire [7:0]  O_HP_RDATA,
    input wire        O_SYNC_PULSE_OUT_A,
    input wire        O_SYNC_PULSE_OUT_B
);
    wire ack = I_PULSE_LEN == 16'h0000;
    wire hra = I_HP_RD && I_HP_ADDR == `SYNC_A_STAT_ADDR;
    wire hrb = I_HP_RD && I_HP_ADDR == `SYNC_B_STAT_ADDR;
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_N);

    AST_ACKA_CLR: assert property (ack && hra && O_SYNC_PULSE_OUT_A
        |=> O_HP_RDATA == 8'h01 && !O_SYNC_PULSE_OUT_A) else $error("output a ack failed");
    AST_ACKB_CLR: assert property (ack && hrb && O_SYNC_PULSE_OUT_B
        |=> O_HP_RDATA == 8'h01 && !O_SYNC_PULSE_OUT_B) else $error("output b ack failed");
    AST_ACKA_HOLD: assert property (ack && I_UNIT_ACTIVATE && O_SYNC_PULSE_OUT_A && !hra
        |=> O_SYNC_PULSE_OUT_A) else $error("output a dropped in ack mode");
    AST_TIMED_LEN: assert property ($rose(O_SYNC_PULSE_OUT_A) && I_PULSE_LEN == 16'h0004
        |=> O_SYNC_PULSE_OUT_A ##1 !O_SYNC_PULSE_OUT_A) else $error("output a width wrong");
    AST_ACT_RSV: assert property (I_NM_RD && I_NM_ADDR == `ACT_STATUS_ADDR
        |=> O_NM_RDATA[7:3] == 5'h00) else $error("activation status reserved set");
    AST_ACKST_RSV: assert property (hra || hrb
        |=> O_HP_RDATA[7:1] == 7'h00) else $error("ack status reserved set");
    AST_CTRL_RSV: assert property (I_HP_RD && I_HP_ADDR[11:1] == 11'h4D4
        |=> O_HP_RDATA[7:2] == 6'h00) else $error("capture control reserved set");
    AST_CAPST_RSV: assert property (I_NM_RD && I_NM_ADDR == `CAP_A_STAT_ADDR
        |=> O_NM_RDATA[7:3] == 5'h00) else $error("capture status reserved set");
    AST_UNMAP: assert property (I_NM_RD && I_NM_ADDR == 12'h985
        |=> O_NM_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule // sync_latch_unit_props

bind sync_latch_unit sync_latch_unit_props u_props (.*);

// >>> tb/sync_app_model.sv
// application side: drives both capture pins, counts output a pulses
// assumes pin requests from the bench settle before the rising edge
`timescale 1ns/1ps
module sync_app_model (
    input  wire       i_clk,
    input  wire       i_sync_a,
    input  wire       i_pin_a,
    input  wire       i_pin_b,
    output reg        o_cap_a = 1'b0,
    output reg        o_cap_b = 1'b0,
    output reg  [7:0] o_cnt_a = 8'h00
);
    reg prev_q = 1'b0;
    always @(posedge i_clk) begin
        o_cap_a <= i_pin_a;
        o_cap_b <= i_pin_b;
        prev_q <= i_sync_a;
        if (i_sync_a && !prev_q) o_cnt_a <= o_cnt_a + 8'h01;
    end
endmodule // sync_app_model

// >>> tb/sync_latch_unit_tb.sv
// self-checking bench of the sync pulse and capture unit
// assumes the register header is on the include path
`timescale 1ns/1ps
module sync_latch_unit_tb;
    reg I_SYS_CLK = 1'b0, I_RST_N = 1'b0, I_FRAME_END = 1'b0, I_AUTO_ACTIVATE = 1'b0;
    reg I_SYNC_OWNER_HOST = 1'b0, I_CAPA_OWNER_HOST = 1'b0, I_CAPB_OWNER_HOST = 1'b0;
    reg I_UNIT_ACTIVATE = 1'b0, I_GEN_A_EN = 1'b0, I_GEN_B_EN = 1'b0, I_PLAUS_CHECK_EN = 1'b0;
    reg I_NM_WR = 1'b0, I_NM_RD = 1'b0, I_HP_WR = 1'b0, I_HP_RD = 1'b0, pa = 1'b0, pb = 1'b0;
    reg [15:0] I_PULSE_LEN = 16'h0004;
    reg [11:0] I_NM_ADDR = 12'h000, I_HP_ADDR = 12'h000;
    reg [7:0]  I_NM_WDATA = 8'h00, I_HP_WDATA = 8'h00, q, ca;
    reg [63:0] I_SYS_TIME = 64'h0, st, v;
    wire [7:0] O_NM_RDATA, O_HP_RDATA, cnt_a;
    wire       O_SYNC_PULSE_OUT_A, O_SYNC_PULSE_OUT_B, I_CAPTURE_INPUT_A, I_CAPTURE_INPUT_B;
    integer    failures = 0, n_tests = 0, n, c;
    localparam [131:0] RA = {12'h984, 12'h98E, 12'h98F, 12'h990, 12'h998, 12'h9A0,
                             12'h9A4, 12'h9A8, 12'h9A9, 12'h9AE, 12'h985};

    always #12.5 I_SYS_CLK = ~I_SYS_CLK;
    always @(negedge I_SYS_CLK) I_SYS_TIME <= I_SYS_TIME + 64'h19;

    sync_latch_unit DUT (.*);
    sync_app_model app (.i_clk(I_SYS_CLK), .i_sync_a(O_SYNC_PULSE_OUT_A), .i_pin_a(pa),
        .i_pin_b(pb), .o_cap_a(I_CAPTURE_INPUT_A), .o_cap_b(I_CAPTURE_INPUT_B), .o_cnt_a(cnt_a));

    task report_and_stop;
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input [63:0] s, input [63:0] e);
        n_tests = n_tests + 1;
        if (s !== e) begin
            failures = failures + 1;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task acc(input h, input w, input [11:0] a, input [7:0] d);
        @(negedge I_SYS_CLK);
        if (h) {I_HP_ADDR, I_HP_WDATA, I_HP_WR, I_HP_RD} = {a, d, w, !w};
        else {I_NM_ADDR, I_NM_WDATA, I_NM_WR, I_NM_RD} = {a, d, w, !w};
        @(negedge I_SYS_CLK);
        {I_HP_WR, I_HP_RD, I_NM_WR, I_NM_RD} = 4'h0;
        q = h ? O_HP_RDATA : O_NM_RDATA;
    endtask
    task rd(input h, input [11:0] a, input [7:0] e);
        acc(h, 1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {56'h0, q}, {56'h0, e});
    endtask
    task wrn(input h, input [11:0] a, input [63:0] d, input integer k);
        for (n = 0; n < k; n = n + 1) acc(h, 1'b1, a + n[11:0], d[8*n +: 8]);
    endtask
    task rdn(input [11:0] a, input integer k);
        v = 64'h0;
        for (n = 0; n < k; n = n + 1) begin
            acc(1'b0, 1'b0, a + n[11:0], 8'h00);
            v[8*n +: 8] = q;
        end
    endtask
    task wt(input b);
        c = 0;
        do begin
            @(negedge I_SYS_CLK);
            c = c + 1;
        end while ((b ? O_SYNC_PULSE_OUT_B : O_SYNC_PULSE_OUT_A) !== 1'b1 && c < 400);
        if (c >= 400) begin
            failures = failures + 1;
            report_and_stop;
        end
    endtask
    task w6;
        repeat (6) @(negedge I_SYS_CLK);
    endtask
    task act(input [63:0] d);
        I_UNIT_ACTIVATE = 1'b0;
        st = I_SYS_TIME + d;
        wrn(1'b0, 12'h990, st, 8);
        I_UNIT_ACTIVATE = 1'b1;
    endtask

    task t_owner;
        for (c = 0; c < 11; c = c + 1) rd(1'b0, RA[12*c +: 12], 8'h00);
        wrn(1'b0, 12'h9A8, 64'hFF, 1);
        rd(1'b0, 12'h9A8, 8'h03);
        wrn(1'b1, 12'h9A8, 64'h00, 1);
        rd(1'b1, 12'h9A8, 8'h03);
        I_CAPB_OWNER_HOST = 1'b1;
        wrn(1'b0, 12'h9A9, 64'h02, 1);
        wrn(1'b1, 12'h9A9, 64'h01, 1);
        rd(1'b0, 12'h9A9, 8'h01);
        wrn(1'b1, 12'h9A0, 64'h55, 1);
        rd(1'b1, 12'h9A0, 8'h00);
        I_SYNC_OWNER_HOST = 1'b1;
        wrn(1'b0, 12'h9A4, 64'h55, 1);
        wrn(1'b1, 12'h9A4, 64'h66, 1);
        rd(1'b0, 12'h9A4, 8'h66);
        I_SYNC_OWNER_HOST = 1'b0;
    endtask
    task t_timed;
        wrn(1'b0, 12'h9A0, 64'h3E8, 4);
        wrn(1'b0, 12'h9A4, 64'h12C, 4);
        {I_GEN_A_EN, I_GEN_B_EN} = 2'b11;
        act(64'h7D0);
        wrn(1'b1, 12'h990, 64'h11, 1);
        rd(1'b0, 12'h984, 8'h03);
        rdn(12'h990, 8);
        chk("next a", v, st);
        wt(1'b0);
        wt(1'b1);
        chk("a to b", c, 12);
        wt(1'b0);
        chk("b to a", c, 28);
        rdn(12'h998, 4);
        chk("next b", v, {32'h0, st[31:0] + 32'h514});
        rd(1'b0, 12'h984, 8'h00);
        rdn(12'h990, 8);
        chk("next a", v, st + 64'h7D0);
    endtask
    task t_single_ack;
        wrn(1'b0, 12'h9A0, 64'h0, 4);
        act(64'h7D0);
        ca = cnt_a;
        wt(1'b0);
        repeat (120) @(negedge I_SYS_CLK);
        chk("pulses", cnt_a - ca, 1);
        chk("out a idle", O_SYNC_PULSE_OUT_A, 0);
        I_PULSE_LEN = 16'h0000;
        act(64'h7D0);
        wt(1'b0);
        wt(1'b1);
        chk("out a held", O_SYNC_PULSE_OUT_A, 1);
        rd(1'b1, 12'h98E, 8'h01);
        chk("out a", O_SYNC_PULSE_OUT_A, 0);
        rd(1'b1, 12'h98F, 8'h01);
        chk("out b", O_SYNC_PULSE_OUT_B, 0);
        I_PULSE_LEN = 16'h0004;
        I_PLAUS_CHECK_EN = 1'b1;
        act(64'hFFFFFFFFFFFFFF38);
        acc(1'b0, 1'b0, 12'h984, 8'h00);
        chk("plaus", q[2], 1);
        I_UNIT_ACTIVATE = 1'b0;
    endtask
    task t_capture;
        wrn(1'b0, 12'h9A8, 64'h01, 1);
        st = I_SYS_TIME;
        pa = 1'b1;
        w6;
        rd(1'b0, 12'h9AE, 8'h05);
        rdn(12'h9B0, 8);
        chk("rise time", v - st <= 64'h96, 1);
        rd(1'b0, 12'h9AE, 8'h04);
        pa = 1'b0;
        w6;
        rd(1'b0, 12'h9AE, 8'h00);
        wrn(1'b0, 12'h9A8, 64'h03, 1);
        st = I_SYS_TIME;
        pa = 1'b1;
        w6;
        pa = 1'b0;
        pb = 1'b1;
        w6;
        pa = 1'b1;
        w6;
        rd(1'b0, 12'h9AE, 8'h07);
        rdn(12'h9B0, 8);
        chk("first rise", v - st <= 64'h96, 1);
        acc(1'b0, 1'b0, 12'h9B8, 8'h00);
        rd(1'b0, 12'h9AE, 8'h04);
        rdn(12'h9C0, 8);
        chk("b rise time", v - st - 64'h96 <= 64'h96, 1);
    endtask
    task fe;
        @(negedge I_SYS_CLK) I_FRAME_END = 1'b1;
        @(negedge I_SYS_CLK) I_FRAME_END = 1'b0;
    endtask
    task t_auto;
        wrn(1'b0, 12'h990, 64'hAAAAAAAA00000000, 8);
        fe;
        I_AUTO_ACTIVATE = 1'b1;
        st = I_SYS_TIME + 64'h7D0;
        wrn(1'b0, 12'h990, st, 4);
        fe;
        rdn(12'h990, 8);
        chk("extended start", v, st);
    endtask

    initial begin
        repeat (5) @(negedge I_SYS_CLK);
        I_RST_N = 1'b1;
        t_owner;
        t_timed;
        t_single_ack;
        t_capture;
        t_auto;
        report_and_stop;
    end
endmodule // sync_latch_unit_tb
